/* File: hppi_top.sv */
// downstream port power switching, over-current handling and port indicators
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module hppi_top #(
	parameter int CYCLES_PER_MS = hppi_pkg::CYCLES_PER_MS,
	parameter int BLINK_HALF_MS = hppi_pkg::BLINK_HALF_MS
) (
	// clock, reset, enable
	input  wire logic                                         clk_i,
	input  wire logic                                         rst_i,
	input  wire logic                                         ce_i,
	// wishbone slave
	input  wire hppi_pkg::hppi_wb_req_t                       wb_i,
	output logic                                              wb_ack_o,
	output logic [31:0]                                       wb_dat_o,
	// port state from the port state machines
	input  wire hppi_pkg::hppi_pstate_t [hppi_pkg::NPORTS-1:0] port_state_i,
	// external power switch
	input  wire logic [hppi_pkg::NPORTS-1:0]                  port_overcurrent_sense_n_i,
	output logic [hppi_pkg::NPORTS-1:0]                       port_power_enable_n_o,
	// indicators
	output logic [hppi_pkg::NPORTS-1:0]                       led_green_o,
	output logic [hppi_pkg::NPORTS-1:0]                       led_amber_o,
	// toward hub controller
	output logic                                              hub_char_ind_o,
	output logic [hppi_pkg::NPORTS-1:0]                       port_change_o
);
	import hppi_pkg::*;

	localparam logic [PRE_W-1:0] CPM_M1 = PRE_W'(CYCLES_PER_MS - 1);
	localparam logic [BLK_W-1:0] BLK_M1 = BLK_W'(BLINK_HALF_MS - 1);

	hppi_state_t       st;
	hppi_state_t       n;
	logic [NPORTS-1:0] qual;
	logic [3:0]        lim [NPORTS];

	function automatic logic hppi_active(input hppi_pstate_t s);
		return s == PS_ENABLED || s == PS_TRANSMIT || s == PS_TRANSMITR;
	endfunction

	// returns {green, amber}
	function automatic logic [1:0] hppi_led(input hppi_ind_t c, input logic g, input logic a, input logic bl);
		case (c)
			IND_AUTO:     return {g, a};
			IND_AMBER:    return 2'b01;
			IND_GREEN:    return 2'b10;
			IND_BLINK_OG: return {bl, 1'b0};
			IND_BLINK_OA: return {1'b0, bl};
			default:      return 2'b00;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++) begin : g_filt
			// enabled and disabled ports qualify with their own time
			assign lim[gi] = hppi_active(port_state_i[gi]) ? st.oc_en_ms : st.oc_dis_ms;
			hppi_oc_filter #(
				.CYCLES_PER_MS(CYCLES_PER_MS)
			) u_filt (
				.clk_i       (clk_i),
				.rst_i       (rst_i),
				.ce_i        (ce_i),
				.sense_n_i   (port_overcurrent_sense_n_i[gi]),
				.limit_ms_i  (lim[gi]),
				.qualified_o (qual[gi])
			);
		end
	endgenerate

	always_comb begin
		logic              hit;
		logic              wr;
		logic [31:0]       rd;
		logic [NPORTS-1:0] set_p;
		logic [NPORTS-1:0] clr_p;
		logic [NPORTS-1:0] rise;
		logic [NPORTS-1:0] rreq;
		logic [NPORTS-1:0] w1c;
		logic [2:0]        code;
		logic              g_a;
		logic              a_a;
		logic [1:0]        led;
		hit   = 1'b0;
		wr    = 1'b0;
		rd    = 32'h0000_0000;
		set_p = '0;
		clr_p = '0;
		rreq  = '0;
		rise  = '0;
		w1c   = '0;
		code  = 3'h0;
		g_a   = 1'b0;
		a_a   = 1'b0;
		led   = 2'b00;
		n     = st;

		// single-cycle classic slave: ack the cycle after the request, then drop it
		hit   = wb_i.cyc && wb_i.stb && !st.ack;
		wr    = hit && wb_i.we;
		n.ack = hit;

		// millisecond prescaler drives the manual blink phase
		if (st.ms_pre == CPM_M1) begin
			n.ms_pre = '0;
			if (st.blk_cnt == BLK_M1) begin
				n.blk_cnt = '0;
				n.blink   = ~st.blink;
			end else begin
				n.blk_cnt = st.blk_cnt + BLK_W'(1);
			end
		end else begin
			n.ms_pre = st.ms_pre + PRE_W'(1);
		end

		case (wb_i.adr)
			ADR_CTRL: begin
				rd[CTRL_GANG]   = st.gang;
				rd[CTRL_IND_EN] = st.ind_en;
				rd[CTRL_CFG]    = st.cfg;
				if (wr && wb_i.sel[0]) begin
					n.gang   = wb_i.dat[CTRL_GANG];
					n.ind_en = wb_i.dat[CTRL_IND_EN];
					n.cfg    = wb_i.dat[CTRL_CFG];
				end
			end
			ADR_OCTIME: begin
				rd[OCT_EN_LSB +: 4]  = st.oc_en_ms;
				rd[OCT_DIS_LSB +: 4] = st.oc_dis_ms;
				if (wr && wb_i.sel[0]) begin
					n.oc_en_ms  = wb_i.dat[OCT_EN_LSB +: 4];
					n.oc_dis_ms = wb_i.dat[OCT_DIS_LSB +: 4];
				end
			end
			ADR_POWER: begin
				rd[NPORTS-1:0] = st.power;
				if (wr && wb_i.sel[0]) begin
					set_p = wb_i.dat[PWR_SET_LSB +: NPORTS];
					clr_p = wb_i.dat[PWR_CLR_LSB +: NPORTS];
				end
			end
			ADR_RESET: begin
				rd[NPORTS-1:0] = st.rst_grn;
				if (wr && wb_i.sel[0]) begin
					rreq = wb_i.dat[NPORTS-1:0];
				end
			end
			ADR_IND: begin
				for (int i = 0; i < NPORTS; i++) begin
					rd[i*IND_NIB +: 3] = st.sel[i];
					code = wb_i.dat[i*IND_NIB +: 3];
					// reserved codes are refused so a port never shows the reserved pattern
					if (wr && wb_i.sel[i/2] && code <= 3'(IND_BLINK_OA)) begin
						n.sel[i] = hppi_ind_t'(code);
						if (code != 3'(IND_AUTO)) begin
							n.ovr[i] = 1'b1;
						end
					end
				end
			end
			ADR_STATUS: begin
				rd[ST_QUAL_LSB +: NPORTS] = qual;
				rd[ST_CHG_LSB +: NPORTS]  = st.chg;
				rd[ST_LAT_LSB +: NPORTS]  = st.oc_lat;
				if (wr && wb_i.sel[0]) begin
					w1c = wb_i.dat[ST_CHG_LSB +: NPORTS];
				end
			end
			default: rd = 32'h0000_0000;
		endcase
		n.dat = hit ? rd : 32'h0000_0000;

		// power commands; ganged switching moves every port together
		if (st.gang) begin
			if (|set_p) begin
				n.power  = '1;
				n.oc_lat = '0;
			end
			if (|clr_p) begin
				n.power = '0;
			end
		end else begin
			n.power  = (st.power | set_p) & ~clr_p;
			n.oc_lat = st.oc_lat & ~set_p;
		end

		// qualified over-current drops power and latches for amber
		rise     = qual & ~st.qual_d;
		n.qual_d = qual;
		// the latch follows the live fault, so a power-set in the same cycle cannot hide it
		n.oc_lat = n.oc_lat | qual;
		if (st.gang && |qual) begin
			n.power = '0;
		end else begin
			n.power = n.power & ~qual;
		end
		if (!n.cfg) begin
			n.power = '0;
		end

		// change flags: a new event wins over a clear in the same cycle
		n.chg = (st.chg & ~w1c) | rise;

		for (int i = 0; i < NPORTS; i++) begin
			if (rreq[i] && !st.ovr[i]) begin
				n.rst_grn[i] = 1'b1;
			end else if (hppi_active(port_state_i[i]) || port_state_i[i] == PS_POWERED_OFF) begin
				n.rst_grn[i] = 1'b0;
			end
			// automatic colours are steady; no blink term enters them
			g_a = hppi_active(port_state_i[i]) || st.rst_grn[i];
			a_a = st.oc_lat[i] && (st.gang ? port_state_i[i] == PS_DISABLED
				: port_state_i[i] == PS_POWERED_OFF);
			led = hppi_led(st.sel[i], g_a, a_a, st.blink);
			n.grn[i] = st.ind_en && led[1];
			n.amb[i] = st.ind_en && led[0];
		end

		n.port_power_enable_n = ~n.power;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st           <= '0;
			st.gang      <= RST_GANG;
			st.ind_en    <= RST_IND_EN;
			st.oc_en_ms  <= RST_OC_MS;
			st.oc_dis_ms <= RST_OC_MS;
			st.port_power_enable_n     <= '1;
			for (int i = 0; i < NPORTS; i++) begin
				st.sel[i] <= IND_AUTO;
			end
		end else if (ce_i) begin
			st <= n;
		end
	end

	assign wb_ack_o              = st.ack;
	assign wb_dat_o              = st.dat;
	assign port_power_enable_n_o = st.port_power_enable_n;
	assign led_green_o           = st.grn;
	assign led_amber_o           = st.amb;
	assign hub_char_ind_o        = st.ind_en;
	assign port_change_o         = st.chg;

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_rst_cmd0;
		ce_i && wb_i.cyc && wb_i.stb && !wb_ack_o && wb_i.we && wb_i.adr == ADR_RESET
			&& wb_i.sel[0] && wb_i.dat[0] && !st.ovr[0];
	endsequence

	sequence s_auto_port0;
		ce_i && st.sel[0] == IND_AUTO && st.ind_en && st.rst_grn[0];
	endsequence

	a_reset_defaults: assert property ($fell(rst_i) |-> &port_power_enable_n_o && hub_char_ind_o
		&& !st.gang && st.oc_en_ms == RST_OC_MS)
		else $error("wrong state after reset");
	a_unconf_unpowered: assert property ((ce_i && !st.cfg) |=> &port_power_enable_n_o)
		else $error("port powered while unconfigured");
	a_oc_power_off: assert property ((ce_i && qual[0]) |=> port_power_enable_n_o[0] && st.oc_lat[0])
		else $error("over-current did not remove power");
	a_gang_all_off: assert property ((ce_i && st.gang && |qual) |=> &port_power_enable_n_o)
		else $error("ganged fault left a port powered");
	a_oc_change_flag: assert property ((ce_i && qual[0] && !st.qual_d[0]) |=> port_change_o[0] [*1])
		else $error("over-current change not reported");
	a_auto_green_on: assert property ((ce_i && st.ind_en && st.sel[0] == IND_AUTO && hppi_active(port_state_i[0]))
		|=> led_green_o[0] && !led_amber_o[0])
		else $error("enabled port not green");
	a_auto_suspend_off: assert property ((ce_i && st.sel[1] == IND_AUTO && !st.rst_grn[1]
		&& port_state_i[1] == PS_SUSPENDED) |=> !led_green_o[1] && !led_amber_o[1])
		else $error("suspended port lit");
	a_auto_steady: assert property ((ce_i && $past(ce_i) && st.sel[0] == IND_AUTO
		&& $past(st.sel[0] == IND_AUTO) && $stable(port_state_i[0]) && $stable(st.rst_grn[0])
		&& $stable(st.oc_lat[0]) && $stable(st.ind_en) && $stable(st.gang))
		|=> $stable(led_green_o[0]) && $stable(led_amber_o[0]))
		else $error("automatic indicator changed with steady inputs");
	a_manual_blink_og: assert property ((ce_i && st.ind_en && st.sel[1] == IND_BLINK_OG)
		|=> led_green_o[1] == $past(st.blink) && !led_amber_o[1])
		else $error("manual blink pattern wrong");
	a_reset_green: assert property (s_rst_cmd0 ##1 s_auto_port0 |=> led_green_o[0])
		else $error("port reset did not light green");
	a_wb_ack_pulse: assert property ((ce_i && wb_i.cyc && wb_i.stb && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus acknowledge not a single cycle");
endmodule

/* File: hppi_pkg.sv */
// shared constants, types and register map of the hub port power and indicator block
package hppi_pkg;

	localparam int NPORTS        = 4;
	localparam int MS_NS         = 1000000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
	localparam int PRE_W         = 18;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLK_W         = 10;

	// byte offsets on the register bus
	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_OCTIME = 8'h04;
	localparam logic [7:0] ADR_POWER  = 8'h08;
	localparam logic [7:0] ADR_RESET  = 8'h0C;
	localparam logic [7:0] ADR_IND    = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;

	// register fields and reset values
	localparam int         CTRL_GANG   = 0;
	localparam int         CTRL_IND_EN = 1;
	localparam int         CTRL_CFG    = 2;
	localparam logic       RST_GANG    = 1'b0;
	localparam logic       RST_IND_EN  = 1'b1;
	localparam logic [3:0] RST_OC_MS   = 4'h8;
	localparam int         OCT_EN_LSB  = 0;
	localparam int         OCT_DIS_LSB = 4;
	localparam int         PWR_SET_LSB = 0;
	localparam int         PWR_CLR_LSB = 4;
	localparam int         ST_QUAL_LSB = 0;
	localparam int         ST_CHG_LSB  = 4;
	localparam int         ST_LAT_LSB  = 8;
	localparam int         IND_NIB     = 4;

	typedef enum logic [3:0] {
		PS_POWERED_OFF, PS_DISCONNECTED, PS_DISABLED, PS_ENABLED, PS_TRANSMIT,
		PS_TRANSMITR, PS_SUSPENDED, PS_RESUMING, PS_SENDEOR, PS_RESTART
	} hppi_pstate_t;

	typedef enum logic [2:0] {
		IND_AUTO, IND_AMBER, IND_GREEN, IND_OFF, IND_BLINK_OG, IND_BLINK_OA, IND_BLINK_GA
	} hppi_ind_t;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} hppi_wb_req_t;

	typedef struct packed {
		logic [PRE_W-1:0] sub;
		logic [3:0]       ms;
		logic             qual;
	} hppi_filt_t;

	typedef struct packed {
		logic [NPORTS-1:0]            power;
		logic [NPORTS-1:0]            oc_lat;
		logic [NPORTS-1:0]            chg;
		logic [NPORTS-1:0]            ovr;
		logic [NPORTS-1:0]            rst_grn;
		logic [NPORTS-1:0]            qual_d;
		hppi_ind_t [NPORTS-1:0]       sel;
		logic                         gang;
		logic                         ind_en;
		logic                         cfg;
		logic [3:0]                   oc_en_ms;
		logic [3:0]                   oc_dis_ms;
		logic [PRE_W-1:0]             ms_pre;
		logic [BLK_W-1:0]             blk_cnt;
		logic                         blink;
		logic                         ack;
		logic [31:0]                  dat;
		logic [NPORTS-1:0]            port_power_enable_n;
		logic [NPORTS-1:0]            grn;
		logic [NPORTS-1:0]            amb;
	} hppi_state_t;

endpackage

/* File: hppi_oc_filter.sv */
// timed qualification filter for one active-low over-current sense input
`timescale 1ns/1ps
module hppi_oc_filter #(
	parameter int CYCLES_PER_MS = hppi_pkg::CYCLES_PER_MS
) (
	// clock, reset, enable
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       ce_i,
	// sense and limit
	input  wire logic       sense_n_i,
	input  wire logic [3:0] limit_ms_i,
	// result
	output logic            qualified_o
);
	import hppi_pkg::*;

	localparam logic [PRE_W-1:0] SUB_M1 = PRE_W'(CYCLES_PER_MS - 1);

	hppi_filt_t st;
	hppi_filt_t n;

	always_comb begin
		n = st;
		if (sense_n_i) begin
			n = '0;
		end else if (!st.qual) begin
			if (st.ms >= limit_ms_i) begin
				n.qual = 1'b1;
			end else if (st.sub == SUB_M1) begin
				n.sub = '0;
				n.ms  = st.ms + 4'h1;
			end else begin
				n.sub = st.sub + PRE_W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= n;
		end
	end

	assign qualified_o = st.qual;

	// helper: length of the current low run, in enabled cycles
	int low_run;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_run <= 0;
		end else if (ce_i) begin
			low_run <= sense_n_i ? 0 : low_run + 1;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_short_pulse_drop: assert property ((ce_i && sense_n_i) |=> !qualified_o)
		else $error("over-current kept after sense released");
	a_qual_min_time: assert property ($rose(qualified_o) |-> low_run >= int'($past(limit_ms_i)) * CYCLES_PER_MS + 1)
		else $error("over-current qualified too early");
endmodule

/* File: hppi_switch_model.sv */
// behavioural external port power switch with bench-commanded overload
`timescale 1ns/1ps
module hppi_switch_model (
	// enables from the hub
	input  wire logic [3:0] enable_n_i,
	// overload commanded by the bench
	input  wire logic [3:0] overload_i,
	// open-drain flags, pulled up when idle
	output logic [3:0]      overcurrent_n_o
);
	// only a powered, loaded channel pulls its flag low; an unpowered one reads the pull-up
	assign overcurrent_n_o = ~(overload_i & ~enable_n_i);
endmodule

/* File: tb_hub_port_power_indicator.sv */
// self-checking bench for the port power and indicator block
`timescale 1ns/1ps
module tb_hub_port_power_indicator;
	import hppi_pkg::*;
	localparam logic [9:0] GE = 10'h048;
	localparam logic [9:0] AE = 10'h102;
	logic                       clk_i;
	logic                       rst_i;
	logic                       ce;
	hppi_wb_req_t               wb_r;
	logic                       wb_ack_o;
	logic [31:0]                wb_dat_o;
	hppi_pstate_t [NPORTS-1:0]  ps;
	logic [3:0]                 sense_n;
	logic [3:0]                 pen;
	logic [3:0]                 grn;
	logic [3:0]                 amb;
	logic                       hci;
	logic [3:0]                 chg;
	logic [3:0]                 fault;
	logic [31:0]                seed;
	logic [7:0]                 gn;
	logic [7:0]                 an;
	logic [31:0]                q[$];
	int                         error_cnt;
	int                         checks;
	int                         tcnt;

	hppi_top #(.CYCLES_PER_MS(10), .BLINK_HALF_MS(2)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb_r), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.port_state_i(ps), .port_overcurrent_sense_n_i(sense_n), .port_power_enable_n_o(pen),
		.led_green_o(grn), .led_amber_o(amb), .hub_char_ind_o(hci), .port_change_o(chg));

	hppi_switch_model sw (.enable_n_i(pen), .overload_i(fault), .overcurrent_n_o(sense_n));

	always #2 clk_i = ~clk_i;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task results();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// steady off, steady on, or toggling within a 60-cycle window
	function automatic logic [1:0] cat(input logic [7:0] n);
		return (n == 8'h00) ? 2'h0 : (n == 8'h3C) ? 2'h2 : 2'h1;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// classic cycle: request held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		wb_r <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && n < 50) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 50)
			chk("wb_ack", 1, 0);
		wb_r <= '0;
		@(posedge clk_i);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		wb(1'b0, a, 32'h0);
	endtask

	// overload port p and count cycles until its enable is dropped
	task automatic oc(input int p, input int lo);
		int n;
		n = 0;
		fault[p] <= 1'b1;
		while (pen[p] !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		fault[p] <= 1'b0;
		chk("oc_dly", 1, 32'(n >= lo + 2 && n <= lo + 4));
	endtask

	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_r.we === 1'b0) begin
			if (q.size() == 0)
				chk("rd_extra", 0, 1);
			else
				chk("rd_dat", q.pop_front(), wb_dat_o);
		end
	end

	always @(posedge clk_i) begin
		tcnt++;
		if (tcnt == 20000) begin
			error_cnt++;
			results();
		end
	end

	initial begin
		int n;
		clk_i = 1'b0;
		rst_i = 1'b1;
		ce = 1'b1;
		wb_r = '0;
		fault = 4'h0;
		seed = 32'hBB77;
		foreach (ps[i]) ps[i] = PS_POWERED_OFF;
		cyc(20);
		rst_i <= 1'b0;
		cyc(1);
		chk("port_power_enable_n", 4'hF, pen);
		chk("ind_present", 1, hci);
		rd(ADR_CTRL, 32'h2);
		rd(ADR_OCTIME, 32'h88);
		rd(ADR_IND, 32'h0);
		rd(8'h20, 32'h0);
		wb(1'b1, ADR_POWER, 32'hF);
		rd(ADR_POWER, 32'h0);
		wb(1'b1, ADR_CTRL, 32'h6);
		wb(1'b1, ADR_POWER, 32'h5);
		chk("port_power_enable_n", 4'hA, pen);
		rd(ADR_POWER, 32'h5);
		for (int s = 0; s < 10; s++) begin
			ps[1] <= hppi_pstate_t'(s);
			cyc(3);
			chk("grn1", 32'(s inside {3, 4, 5}), grn[1]);
			cyc(45);
			chk("grn1", 32'(s inside {3, 4, 5}), grn[1]);
			chk("amb1", 0, amb[1]);
		end
		// random pulses, each shorter than 8 ms but longer together
		ps[0] <= PS_ENABLED;
		repeat (3) begin
			n = 40 + int'(xs() % 30);
			fault[0] <= 1'b1;
			cyc(n);
			fault[0] <= 1'b0;
			cyc(2);
		end
		chk("pwr0", 0, pen[0]);
		rd(ADR_STATUS, 32'h0);
		oc(0, 80);
		cyc(2);
		chk("chg", 4'h1, chg);
		rd(ADR_STATUS, 32'h110);
		ps[0] <= PS_POWERED_OFF;
		cyc(3);
		chk("amb0", 1, amb[0]);
		chk("grn0", 0, grn[0]);
		ps[0] <= PS_DISABLED;
		cyc(3);
		chk("amb0", 0, amb[0]);
		wb(1'b1, ADR_STATUS, 32'h10);
		chk("chg", 4'h0, chg);
		wb(1'b1, ADR_OCTIME, 32'h30);
		ps[2] <= PS_DISABLED;
		oc(2, 30);
		ps[2] <= PS_ENABLED;
		wb(1'b1, ADR_POWER, 32'h4);
		oc(2, 0);
		wb(1'b1, ADR_CTRL, 32'h7);
		wb(1'b1, ADR_POWER, 32'hF0);
		wb(1'b1, ADR_POWER, 32'h1);
		chk("pwr_gang", 4'h0, pen);
		oc(3, 30);
		chk("pwr_gang", 4'hF, pen);
		ps[3] <= PS_DISABLED;
		cyc(3);
		chk("amb3", 1, amb[3]);
		wb(1'b1, ADR_CTRL, 32'h6);
		for (int c = 1; c <= 5; c++) begin
			wb(1'b1, ADR_IND, 32'(c) << 4);
			cyc(3);
			gn = 8'h0;
			an = 8'h0;
			repeat (60) begin
				@(posedge clk_i);
				gn = gn + 8'(grn[1]);
				an = an + 8'(amb[1]);
			end
			chk("man_g", GE[2 * (c - 1) +: 2], cat(gn));
			chk("man_a", AE[2 * (c - 1) +: 2], cat(an));
		end
		// a low enable freezes the blink phase, so the lit pattern must hold
		ce <= 1'b0;
		cyc(2);
		an = 8'(amb[1]);
		cyc(45);
		chk("freeze_amb1", an, 8'(amb[1]));
		ce <= 1'b1;
		wb(1'b1, ADR_IND, 32'h60);
		rd(ADR_IND, 32'h50);
		wb(1'b1, ADR_IND, 32'h30);
		ps[2] <= PS_DISABLED;
		wb(1'b1, ADR_RESET, 32'h7);
		cyc(3);
		chk("grn2", 1, grn[2]);
		chk("grn0", 1, grn[0]);
		chk("grn1", 0, grn[1]);
		rd(ADR_RESET, 32'h5);
		wb(1'b1, ADR_CTRL, 32'h4);
		cyc(2);
		chk("ind_present", 0, hci);
		chk("leds", 8'h0, {grn, amb});
		results();
	end
endmodule
